// *** rtl/mpd_bus_timer.sv ***
`timescale 1ns/1ps
module mpd_bus_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        three_state_i,
  input  wire logic        word_i,
  output mpd_pkg::mpd_bus_e bus_state_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             second_cycle_o
);

  mpd_pkg::mpd_bus_e state_reg;
  mpd_pkg::mpd_bus_e state_next;
  logic              three_reg;
  logic              three_next;
  logic              word_reg;
  logic              word_next;
  logic              second_reg;
  logic              second_next;
  logic              last_state;

  // Final state of a cycle: second for on-chip memory, third otherwise
  assign last_state = three_reg ? (state_reg == mpd_pkg::THIRD_BUS_STATE)
                                : (state_reg == mpd_pkg::SECOND_BUS_STATE);

  always_comb
  begin
    state_next  = state_reg;
    three_next  = three_reg;
    word_next   = word_reg;
    second_next = second_reg;
    case (state_reg)
      mpd_pkg::BUS_IDLE:
      begin
        if (start_i)
        begin
          state_next  = mpd_pkg::FIRST_BUS_STATE;
          three_next  = three_state_i;
          word_next   = word_i;
          second_next = 1'b0;
        end
      end
      mpd_pkg::FIRST_BUS_STATE:
        state_next = mpd_pkg::SECOND_BUS_STATE;
      mpd_pkg::SECOND_BUS_STATE:
        state_next = three_reg ? mpd_pkg::THIRD_BUS_STATE : mpd_pkg::BUS_IDLE;
      mpd_pkg::THIRD_BUS_STATE:
      begin
        // A word over the byte path takes a second back-to-back cycle
        if (word_reg && !second_reg)
        begin
          state_next  = mpd_pkg::FIRST_BUS_STATE;
          second_next = 1'b1;
        end
        else
        begin
          state_next = mpd_pkg::BUS_IDLE;
        end
      end
      default:
        state_next = mpd_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg  <= mpd_pkg::BUS_IDLE;
      three_reg  <= 1'b0;
      word_reg   <= 1'b0;
      second_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      three_reg  <= three_next;
      word_reg   <= word_next;
      second_reg <= second_next;
    end
  end

  assign bus_state_o    = state_reg;
  assign busy_o         = (state_reg != mpd_pkg::BUS_IDLE);
  assign done_o         = last_state && !(three_reg && word_reg && !second_reg);
  assign second_cycle_o = second_reg;

  default clocking bt_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence two_state_cycle;
    bus_state_o == mpd_pkg::FIRST_BUS_STATE ##1
    bus_state_o == mpd_pkg::SECOND_BUS_STATE && done_o;
  endsequence

  sequence byte_cycle;
    bus_state_o == mpd_pkg::FIRST_BUS_STATE ##1
    bus_state_o == mpd_pkg::SECOND_BUS_STATE ##1
    bus_state_o == mpd_pkg::THIRD_BUS_STATE;
  endsequence

  mem_two_state_a: assert property (
    (start_i && !busy_o && !three_state_i) |=> two_state_cycle ##1 !busy_o)
    else $error("On-chip memory cycle is not two states");

  regf_word_six_a: assert property (
    (start_i && !busy_o && three_state_i && word_i) |=>
      byte_cycle ##1 (byte_cycle and second_cycle_o[*3]) ##0 done_o)
    else $error("Word over byte path is not two three-state cycles");

endmodule

// *** rtl/mpd_defines.svh ***
`ifndef MPD_DEFINES_SVH
`define MPD_DEFINES_SVH

// Register addresses
`define MPD_ADDR_SYS_CTRL   16'hffc4
`define MPD_ADDR_MODE_RB    16'hffc5

// System control field positions
`define MPD_SC_STANDBY_PIN_N_SEL     7
`define MPD_SC_SETTLE_HI    6
`define MPD_SC_SETTLE_LO    4
`define MPD_SC_RST_SRC      3
`define MPD_SC_NMI_EDGE     2
`define MPD_SC_HOST_EN      1
`define MPD_SC_RAM_EN       0

// Reset values and masks
`define MPD_SC_RESET        8'h09
`define MPD_SC_WDT_RESET    8'h01
`define MPD_SC_WR_MASK      8'hf7
`define MPD_MR_FIXED        8'he4
`define MPD_MR_PIN_MASK     8'h03
`define MPD_RD_UNMAPPED     8'h00

// Address map of on-chip resources
`define MPD_ROM_LAST        16'h7fff
`define MPD_RAM_FIRST       16'hf780
`define MPD_RAM_LAST        16'hff7f
`define MPD_REGF_FIRST      16'hff80

// Mode pin codes
`define MPD_MODE_EXP_NOROM  2'h1
`define MPD_MODE_SINGLE     2'h3

// Timing in states (one state per clock)
`define MPD_SETTLE_BASE     8192
`define MPD_SETTLE_MAX_SHF  4

`endif

// *** rtl/mpd_pkg.sv ***
package mpd_pkg;

  typedef enum logic [3:0] {
    SEQ_RESET_HOLD,
    SEQ_RUN,
    SEQ_PUSH_PC,
    SEQ_PUSH_CCR,
    SEQ_SET_MASK,
    SEQ_VECTOR,
    SEQ_BRANCH,
    SEQ_SLEEP,
    SEQ_SW_STANDBY,
    SEQ_SETTLE,
    SEQ_HW_STANDBY
  } mpd_seq_e;

  typedef enum logic [1:0] {
    BUS_IDLE,
    FIRST_BUS_STATE,
    SECOND_BUS_STATE,
    THIRD_BUS_STATE
  } mpd_bus_e;

endpackage

// *** rtl/mpd_top.sv ***
`timescale 1ns/1ps
`include "mpd_defines.svh"
// Behaviour
// - Interrupt entry pushes PC and CCR; reset entry skips the push.
// - Then set interrupt mask, fetch vector, branch back to program execution.
// - Sleep with standby select 0 halts CPU only; peripherals keep running.
// - Interrupt or reset wakes sleep through the exception sequence.
// - Sleep with standby select 1 halts and reinitialises peripherals; RAM, ports kept.
// - Standby pin low stops everything, ports included; peripherals reinit, RAM kept.
// - On-chip ROM/RAM cycles take two states, byte or word, 16-bit path.
// - Register field and external cycles take three states; words take two cycles.
// - Mode is captured from the two mode pins when reset ends.
// - Pin codes select mode 1, 2 or 3; expanded modes address 64 kbytes.
// - In expanded modes, RAM enable 0 routes RAM addresses off-chip.
// - Standby select stays 1 after wake-up until software writes 0.
// - Settling field picks 8192 to 131072 states of wake-up wait.
// - CPU and peripherals stay in standby during the settling wait.
// - Reset-source flag is 1 after external reset, 0 after watchdog reset.
// - Edge select 0 picks falling, 1 rising non-maskable interrupt edge.
// - Host-port enable 0 disables host interface, 1 enables it as slave.
// - RAM enable 1 enables RAM; reset sets it; software standby keeps it.
// - Reading mode readback latches mode pins into its two low bits.
module mpd_top #(
  parameter int SETTLE_BASE_STATES = `MPD_SETTLE_BASE
) (
  input  wire logic         CORE_CLK_I,
  input  wire logic         RESET_I,
  input  wire logic         WDT_RESET_I,
  input  wire logic         STANDBY_PIN_N_I,
  input  wire logic         MODE_PIN_HIGH_I,
  input  wire logic         MODE_PIN_LOW_I,
  input  wire logic         IRQ_REQ_I,
  input  wire logic         EXT_IRQ_WAKE_I,
  input  wire logic         SLEEP_EXEC_I,
  input  wire logic [15:0]  REG_ADDR_I,
  input  wire logic         REG_WR_I,
  input  wire logic         REG_RD_I,
  input  wire logic [7:0]   REG_WDATA_I,
  output logic      [7:0]   REG_RDATA_O,
  input  wire logic         BUS_REQ_I,
  input  wire logic [15:0]  BUS_ADDR_I,
  input  wire logic         BUS_WORD_I,
  output logic              BUS_ACCEPT_O,
  output mpd_pkg::mpd_bus_e BUS_STATE_O,
  output logic              BUS_DONE_O,
  output logic              BUS_SECOND_BYTE_O,
  output logic              BUS_EXTERNAL_O,
  output logic              BUS_WIDE_PATH_O,
  output logic              CPU_HALT_O,
  output logic              PERIPH_HALT_O,
  output logic              PERIPH_INIT_O,
  output logic              PORT_OUT_OFF_O,
  output logic              EXC_PUSH_PC_O,
  output logic              EXC_PUSH_CCR_O,
  output logic              EXC_SET_IMASK_O,
  output logic              EXC_VECTOR_FETCH_O,
  output logic              EXC_BRANCH_O,
  output logic              EXC_FROM_RESET_O,
  output logic      [1:0]   MODE_O,
  output logic              EXPANDED_MODE_O,
  output logic              ROM_ENABLE_O,
  output logic              RAM_ENABLE_O,
  output logic              NMI_RISING_EDGE_O,
  output logic              HOST_PORT_ENABLE_O
);

  mpd_pkg::mpd_seq_e seq_reg;
  mpd_pkg::mpd_seq_e seq_next;
  logic        exc_reset_reg;
  logic        exc_reset_next;
  logic [17:0] settle_reg;
  logic [17:0] settle_next;
  logic [17:0] settle_len;
  logic [2:0]  settle_sel;
  logic [1:0]  mode_reg;
  logic [1:0]  mode_next;
  logic [7:0]  system_control_reg;
  logic [7:0]  system_control_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        ext_reg;
  logic        ext_next;
  logic        wide_reg;
  logic        wide_next;
  logic        standby_pin_n_sel;
  logic        sc_write;
  logic        in_regf;
  logic        in_ram;
  logic        in_rom;
  logic        two_state;
  logic        bus_busy;
  logic        bus_start;

  assign standby_pin_n_sel   = system_control_reg[`MPD_SC_STANDBY_PIN_N_SEL];
  assign settle_sel = system_control_reg[`MPD_SC_SETTLE_HI:`MPD_SC_SETTLE_LO];
  assign sc_write   = REG_WR_I && (REG_ADDR_I == `MPD_ADDR_SYS_CTRL);

  // Wait doubles per code step; 10x and the unused 11x give the longest wait
  assign settle_len = 18'(SETTLE_BASE_STATES << (settle_sel[2] ? `MPD_SETTLE_MAX_SHF
                                                              : int'(settle_sel[1:0])));

  // Exception and power-down sequencer; watchdog reset, then standby pin win
  always_comb
  begin
    seq_next       = seq_reg;
    exc_reset_next = exc_reset_reg;
    settle_next    = settle_reg;
    mode_next      = mode_reg;
    if (WDT_RESET_I)
    begin
      seq_next = mpd_pkg::SEQ_RESET_HOLD;
    end
    else if (!STANDBY_PIN_N_I)
    begin
      seq_next = mpd_pkg::SEQ_HW_STANDBY;
    end
    else
    begin
      case (seq_reg)
        mpd_pkg::SEQ_RESET_HOLD:
        begin
          seq_next       = mpd_pkg::SEQ_SET_MASK;
          exc_reset_next = 1'b1;
          mode_next      = {MODE_PIN_HIGH_I, MODE_PIN_LOW_I};
        end
        mpd_pkg::SEQ_RUN:
        begin
          if (IRQ_REQ_I)
          begin
            seq_next = mpd_pkg::SEQ_PUSH_PC;
          end
          else if (SLEEP_EXEC_I)
          begin
            seq_next = standby_pin_n_sel ? mpd_pkg::SEQ_SW_STANDBY : mpd_pkg::SEQ_SLEEP;
          end
        end
        mpd_pkg::SEQ_SLEEP:
        begin
          if (IRQ_REQ_I)
          begin
            seq_next = mpd_pkg::SEQ_PUSH_PC;
          end
        end
        mpd_pkg::SEQ_SW_STANDBY:
        begin
          if (EXT_IRQ_WAKE_I)
          begin
            seq_next    = mpd_pkg::SEQ_SETTLE;
            settle_next = settle_len - 18'h0_0001;
          end
        end
        mpd_pkg::SEQ_SETTLE:
        begin
          if (settle_reg == 18'h0_0000)
          begin
            seq_next = mpd_pkg::SEQ_PUSH_PC;
          end
          else
          begin
            settle_next = settle_reg - 18'h0_0001;
          end
        end
        mpd_pkg::SEQ_PUSH_PC:
          seq_next = mpd_pkg::SEQ_PUSH_CCR;
        mpd_pkg::SEQ_PUSH_CCR:
          seq_next = mpd_pkg::SEQ_SET_MASK;
        mpd_pkg::SEQ_SET_MASK:
          seq_next = mpd_pkg::SEQ_VECTOR;
        mpd_pkg::SEQ_VECTOR:
          seq_next = mpd_pkg::SEQ_BRANCH;
        mpd_pkg::SEQ_BRANCH:
        begin
          seq_next       = mpd_pkg::SEQ_RUN;
          exc_reset_next = 1'b0;
        end
        mpd_pkg::SEQ_HW_STANDBY:
          seq_next = mpd_pkg::SEQ_RESET_HOLD;
        default:
          seq_next = mpd_pkg::SEQ_RUN;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      seq_reg       <= mpd_pkg::SEQ_RESET_HOLD;
      exc_reset_reg <= 1'b1;
      settle_reg    <= 18'h0_0000;
      mode_reg      <= `MPD_MODE_SINGLE;
    end
    else
    begin
      seq_reg       <= seq_next;
      exc_reset_reg <= exc_reset_next;
      settle_reg    <= settle_next;
      mode_reg      <= mode_next;
    end
  end

  // System control register and read port
  always_comb
  begin
    system_control_next = system_control_reg;
    rdata_next = rdata_reg;
    if (WDT_RESET_I)
    begin
      system_control_next = `MPD_SC_WDT_RESET;
    end
    else if (sc_write)
    begin
      system_control_next = (REG_WDATA_I & `MPD_SC_WR_MASK) | (system_control_reg & ~`MPD_SC_WR_MASK);
    end
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `MPD_ADDR_SYS_CTRL:
          rdata_next = system_control_reg;
        `MPD_ADDR_MODE_RB:
          rdata_next = `MPD_MR_FIXED | {6'h00, MODE_PIN_HIGH_I, MODE_PIN_LOW_I};
        default:
          rdata_next = `MPD_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      system_control_reg <= `MPD_SC_RESET;
      rdata_reg <= `MPD_RD_UNMAPPED;
    end
    else
    begin
      system_control_reg <= system_control_next;
      rdata_reg <= rdata_next;
    end
  end

  // Bus cycle classification
  assign in_regf   = (BUS_ADDR_I >= `MPD_REGF_FIRST);
  assign in_ram    = (BUS_ADDR_I >= `MPD_RAM_FIRST) && (BUS_ADDR_I <= `MPD_RAM_LAST);
  assign in_rom    = (BUS_ADDR_I <= `MPD_ROM_LAST);
  assign two_state = (in_ram && system_control_reg[`MPD_SC_RAM_EN]) ||
                     (in_rom && (mode_reg != `MPD_MODE_EXP_NOROM));
  assign bus_start = BUS_REQ_I && !bus_busy && !CPU_HALT_O;

  always_comb
  begin
    ext_next  = ext_reg;
    wide_next = wide_reg;
    if (bus_start)
    begin
      ext_next  = (mode_reg != `MPD_MODE_SINGLE) && !in_regf && !two_state;
      wide_next = two_state;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      ext_reg  <= 1'b0;
      wide_reg <= 1'b0;
    end
    else
    begin
      ext_reg  <= ext_next;
      wide_reg <= wide_next;
    end
  end

  mpd_bus_timer u_bus_timer (
    .clk_i          (CORE_CLK_I),
    .rst_i          (RESET_I),
    .start_i        (bus_start),
    .three_state_i  (!two_state),
    .word_i         (BUS_WORD_I),
    .bus_state_o    (BUS_STATE_O),
    .busy_o         (bus_busy),
    .done_o         (BUS_DONE_O),
    .second_cycle_o (BUS_SECOND_BYTE_O)
  );

  assign BUS_ACCEPT_O       = bus_start;
  assign BUS_EXTERNAL_O     = ext_reg;
  assign BUS_WIDE_PATH_O    = wide_reg;
  assign REG_RDATA_O        = rdata_reg;

  assign CPU_HALT_O         = (seq_reg == mpd_pkg::SEQ_RESET_HOLD) ||
                              (seq_reg == mpd_pkg::SEQ_SLEEP) || PERIPH_HALT_O;
  assign PERIPH_HALT_O      = (seq_reg == mpd_pkg::SEQ_SW_STANDBY) ||
                              (seq_reg == mpd_pkg::SEQ_SETTLE) ||
                              (seq_reg == mpd_pkg::SEQ_HW_STANDBY);
  assign PERIPH_INIT_O      = PERIPH_HALT_O;
  assign PORT_OUT_OFF_O     = (seq_reg == mpd_pkg::SEQ_HW_STANDBY);
  assign EXC_PUSH_PC_O      = (seq_reg == mpd_pkg::SEQ_PUSH_PC);
  assign EXC_PUSH_CCR_O     = (seq_reg == mpd_pkg::SEQ_PUSH_CCR);
  assign EXC_SET_IMASK_O    = (seq_reg == mpd_pkg::SEQ_SET_MASK);
  assign EXC_VECTOR_FETCH_O = (seq_reg == mpd_pkg::SEQ_VECTOR);
  assign EXC_BRANCH_O       = (seq_reg == mpd_pkg::SEQ_BRANCH);
  assign EXC_FROM_RESET_O   = exc_reset_reg;
  assign MODE_O             = mode_reg;
  assign EXPANDED_MODE_O    = (mode_reg != `MPD_MODE_SINGLE);
  assign ROM_ENABLE_O       = (mode_reg != `MPD_MODE_EXP_NOROM);
  assign RAM_ENABLE_O       = system_control_reg[`MPD_SC_RAM_EN];
  assign NMI_RISING_EDGE_O  = system_control_reg[`MPD_SC_NMI_EDGE];
  assign HOST_PORT_ENABLE_O = system_control_reg[`MPD_SC_HOST_EN];

  // Cycles spent in the settling wait
  logic [17:0] settle_seen;
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      settle_seen <= 18'h0_0000;
    else
      settle_seen <= (seq_reg == mpd_pkg::SEQ_SETTLE) ? settle_seen + 18'h0_0001
                                                      : 18'h0_0000;
  end

  default clocking mpd_cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence entry_tail;
    EXC_SET_IMASK_O ##1 EXC_VECTOR_FETCH_O ##1 EXC_BRANCH_O ##1 !CPU_HALT_O;
  endsequence

  irq_entry_a: assert property (
    disable iff (RESET_I || WDT_RESET_I || !STANDBY_PIN_N_I)
    (seq_reg == mpd_pkg::SEQ_RUN && IRQ_REQ_I) |=> EXC_PUSH_PC_O ##1 EXC_PUSH_CCR_O)
    else $error("Interrupt entry did not push PC then CCR");

  reset_entry_a: assert property (
    disable iff (RESET_I || WDT_RESET_I || !STANDBY_PIN_N_I)
    (seq_reg == mpd_pkg::SEQ_RESET_HOLD) |=> (!EXC_PUSH_PC_O) and entry_tail)
    else $error("Reset entry pushed or broke the mask-vector-branch order");

  sleep_entry_a: assert property (
    (seq_reg == mpd_pkg::SEQ_RUN && SLEEP_EXEC_I && !IRQ_REQ_I && !standby_pin_n_sel &&
     !WDT_RESET_I && STANDBY_PIN_N_I) |=> CPU_HALT_O && !PERIPH_HALT_O)
    else $error("Sleep did not halt only the CPU");

  sleep_wake_a: assert property (
    disable iff (RESET_I || WDT_RESET_I || !STANDBY_PIN_N_I)
    (seq_reg == mpd_pkg::SEQ_SLEEP && IRQ_REQ_I) |=> EXC_PUSH_PC_O ##4 EXC_BRANCH_O)
    else $error("Sleep wake-up skipped the exception sequence");

  soft_standby_a: assert property (
    (seq_reg == mpd_pkg::SEQ_RUN && SLEEP_EXEC_I && !IRQ_REQ_I && standby_pin_n_sel &&
     !WDT_RESET_I && STANDBY_PIN_N_I) |=> PERIPH_INIT_O && CPU_HALT_O && !PORT_OUT_OFF_O)
    else $error("Software standby entry wrong");

  hard_standby_a: assert property (
    (!STANDBY_PIN_N_I && !WDT_RESET_I) |=> PORT_OUT_OFF_O && PERIPH_INIT_O && CPU_HALT_O)
    else $error("Standby pin low did not stop the chip");

  mode_capture_a: assert property (
    (seq_reg == mpd_pkg::SEQ_RESET_HOLD && !WDT_RESET_I && STANDBY_PIN_N_I) |=>
      MODE_O == $past({MODE_PIN_HIGH_I, MODE_PIN_LOW_I}))
    else $error("Mode not captured at reset exit");

  ram_routing_a: assert property (
    (bus_start && in_ram && !system_control_reg[`MPD_SC_RAM_EN] && EXPANDED_MODE_O) |=>
      BUS_EXTERNAL_O && BUS_STATE_O == mpd_pkg::FIRST_BUS_STATE ##2
      BUS_STATE_O == mpd_pkg::THIRD_BUS_STATE)
    else $error("Disabled RAM range not routed off-chip");

  standby_keep_a: assert property (
    (standby_pin_n_sel && !sc_write && !WDT_RESET_I) |=> standby_pin_n_sel)
    else $error("Standby select cleared without a write");

  settle_len_a: assert property (
    (seq_reg == mpd_pkg::SEQ_SETTLE && seq_next == mpd_pkg::SEQ_PUSH_PC) |->
      settle_seen + 18'h0_0001 == settle_len)
    else $error("Settling wait length wrong");

  settle_hold_a: assert property (
    (seq_reg == mpd_pkg::SEQ_SETTLE) |-> CPU_HALT_O && PERIPH_HALT_O && !EXC_PUSH_PC_O)
    else $error("CPU or peripherals left standby during settling");

  reset_source_a: assert property (
    WDT_RESET_I |=> !system_control_reg[`MPD_SC_RST_SRC] && RAM_ENABLE_O)
    else $error("Watchdog reset did not clear the source flag");

  readback_latch_a: assert property (
    (REG_RD_I && REG_ADDR_I == `MPD_ADDR_MODE_RB) |=>
      REG_RDATA_O == (`MPD_MR_FIXED | {6'h00, $past(MODE_PIN_HIGH_I), $past(MODE_PIN_LOW_I)}))
    else $error("Mode readback did not latch the pins");

  flag_write_a: assert property (
    (sc_write && !WDT_RESET_I) |=> system_control_reg[`MPD_SC_RST_SRC] == $past(system_control_reg[3]))
    else $error("Write changed the reset-source flag");

endmodule

// *** tb/mpd_ext_dev.sv ***
`timescale 1ns/1ps
module mpd_ext_dev (
  input  wire logic       clk_i,
  input  wire logic [1:0] bus_state_i,
  input  wire logic       external_i,
  output logic      [7:0] byte_count_o
);
  // Off-chip device: one byte moves in the third state of each cycle
  initial byte_count_o = 8'h00;
  always @(posedge clk_i)
  begin
    if (external_i && bus_state_i == mpd_pkg::THIRD_BUS_STATE)
    begin
      byte_count_o <= byte_count_o + 8'h01;
    end
  end
endmodule

// *** tb/tb_mpd_top.sv ***
`timescale 1ns/1ps
module tb_mpd_top;
  typedef struct packed {
    logic [1:0]  kind;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        word;
    logic [7:0]  exp;
  } mpd_row_s;
  logic              clk, rst, wdt, standby_pin_n_n, mh, ml, irq, wake, slp, rwr, rrd, breq, bw;
  logic       [15:0] ra, ba;
  logic       [7:0]  wd, rd, xb;
  logic              acc, done, sec, ext, wide, ch, ph, pi, po, ppc, pcc, msk, vf, br, fr;
  logic              exm, rom, ram, nmi, host;
  logic       [1:0]  mode;
  mpd_pkg::mpd_bus_e bst;
  int                num_errors, check_count, np, n0;
  int                mseq[3] = '{3, 1, 2};
  int                sc[4] = '{0, 1, 3, 4};
  logic              sm;
  mpd_row_s          rows[14] = '{
    '{2'h1, 16'hffc4, 8'h00, 1'b0, 8'h09},
    '{2'h1, 16'hffc5, 8'h00, 1'b0, 8'he6},
    '{2'h0, 16'hffc5, 8'h00, 1'b0, 8'h00},
    '{2'h1, 16'hffc5, 8'h00, 1'b0, 8'he6},
    '{2'h1, 16'hffc6, 8'h00, 1'b0, 8'h00},
    '{2'h2, 16'h0100, 8'h00, 1'b0, 8'h42},
    '{2'h2, 16'h0100, 8'h00, 1'b1, 8'h42},
    '{2'h2, 16'hffc4, 8'h00, 1'b0, 8'h03},
    '{2'h2, 16'hffc4, 8'h00, 1'b1, 8'h06},
    '{2'h2, 16'h8000, 8'h00, 1'b0, 8'h83},
    '{2'h2, 16'hf800, 8'h00, 1'b1, 8'h42},
    '{2'h0, 16'hffc4, 8'h06, 1'b0, 8'h00},
    '{2'h1, 16'hffc4, 8'h00, 1'b0, 8'h0e},
    '{2'h2, 16'hf800, 8'h00, 1'b1, 8'h86}
  };

  mpd_top #(.SETTLE_BASE_STATES(4)) u_mpd_top (
    .CORE_CLK_I(clk), .RESET_I(rst), .WDT_RESET_I(wdt), .STANDBY_PIN_N_I(standby_pin_n_n),
    .MODE_PIN_HIGH_I(mh), .MODE_PIN_LOW_I(ml), .IRQ_REQ_I(irq), .EXT_IRQ_WAKE_I(wake),
    .SLEEP_EXEC_I(slp), .REG_ADDR_I(ra), .REG_WR_I(rwr), .REG_RD_I(rrd),
    .REG_WDATA_I(wd), .REG_RDATA_O(rd), .BUS_REQ_I(breq), .BUS_ADDR_I(ba),
    .BUS_WORD_I(bw), .BUS_ACCEPT_O(acc), .BUS_STATE_O(bst), .BUS_DONE_O(done),
    .BUS_SECOND_BYTE_O(sec), .BUS_EXTERNAL_O(ext), .BUS_WIDE_PATH_O(wide),
    .CPU_HALT_O(ch), .PERIPH_HALT_O(ph), .PERIPH_INIT_O(pi), .PORT_OUT_OFF_O(po),
    .EXC_PUSH_PC_O(ppc), .EXC_PUSH_CCR_O(pcc), .EXC_SET_IMASK_O(msk),
    .EXC_VECTOR_FETCH_O(vf), .EXC_BRANCH_O(br), .EXC_FROM_RESET_O(fr), .MODE_O(mode),
    .EXPANDED_MODE_O(exm), .ROM_ENABLE_O(rom), .RAM_ENABLE_O(ram),
    .NMI_RISING_EDGE_O(nmi), .HOST_PORT_ENABLE_O(host)
  );

  mpd_ext_dev u_mpd_ext_dev (.clk_i(clk), .bus_state_i(bst), .external_i(ext), .byte_count_o(xb));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic close_out;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang;
    num_errors++;
    close_out;
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_op(input logic w, input logic [15:0] a, input logic [7:0] d);
    step;
    ra = a;
    wd = d;
    rwr = w;
    rrd = !w;
    step;
    rwr = 1'b0;
    rrd = 1'b0;
  endtask

  task automatic bus_op(input logic [15:0] a, input logic w, input logic [7:0] exp);
    int         n;
    logic       e;
    logic       wp;
    logic [7:0] b0;
    b0 = xb;
    step;
    ba = a;
    bw = w;
    breq = 1'b1;
    @(negedge clk);
    for (n = 0; acc !== 1'b1; n++)
    begin
      if (n > 20) hang;
      @(negedge clk);
    end
    step;
    breq = 1'b0;
    @(negedge clk);
    e = ext;
    wp = wide;
    n = 1;
    while (done !== 1'b1)
    begin
      if (n > 20) hang;
      @(negedge clk);
      n++;
    end
    chk({e, wp, n[5:0]}, exp);
    chk(sec, {7'h00, exp[5:0] == 6'h06});
    @(negedge clk);
    chk(xb - b0, e ? (w ? 8'h02 : 8'h01) : 8'h00);
  endtask

  task automatic exc_walk(input logic push);
    @(negedge clk);
    step;
    irq = 1'b0;
    for (int i = 0; i < (push ? 5 : 3); i++)
    begin
      @(negedge clk);
      chk({ppc, pcc, msk, vf, br}, (push ? 8'h10 : 8'h04) >> i);
      if (i == 0) chk(fr, !push);
    end
    @(negedge clk);
    chk(ch, 8'h00);
  endtask

  task automatic wait_run(input logic hold);
    np = -1;
    sm = 1'b0;
    for (int i = 0; !(sm && ch === 1'b0); i++)
    begin
      if (i > 300) hang;
      @(negedge clk);
      if (np < 0 && ppc === 1'b1) np = i;
      if (msk === 1'b1) sm = 1'b1;
      if (hold && np < 0) chk(ph, 8'h01);
    end
  endtask

  task automatic do_reset(input logic h, input logic l);
    step;
    rst = 1'b1;
    mh = h;
    ml = l;
    repeat (8) step;
    rst = 1'b0;
    exc_walk(1'b0);
  endtask

  initial
  begin
    {rst, wdt, standby_pin_n_n, mh, ml, irq, wake, slp} = 8'hb8;
    {ra, ba, wd, rwr, rrd, breq, bw} = 44'h000_0000_0000;
    num_errors = 0;
    check_count = 0;
    foreach (mseq[i])
    begin
      do_reset(mseq[i][1], mseq[i][0]);
      chk({mode, exm, rom, nmi, host, ram}, {mseq[i][1:0], mseq[i] != 3, mseq[i] != 1, 3'h1});
    end
    foreach (rows[i])
    begin
      if (rows[i].kind == 2'h2) bus_op(rows[i].addr, rows[i].word, rows[i].exp);
      else reg_op(rows[i].kind == 2'h0, rows[i].addr, rows[i].data);
      if (rows[i].kind == 2'h1) chk(rd, rows[i].exp);
    end
    chk({ram, host, nmi}, 8'h03);
    reg_op(1'b1, 16'hffc4, 8'h01);
    step;
    slp = 1'b1;
    step;
    slp = 1'b0;
    @(negedge clk);
    chk({ch, ph, pi, po}, 8'h08);
    step;
    irq = 1'b1;
    exc_walk(1'b1);
    step;
    irq = 1'b1;
    exc_walk(1'b1);
    foreach (sc[i])
    begin
      reg_op(1'b1, 16'hffc4, {1'b1, sc[i][2:0], 4'h0});
      step;
      slp = 1'b1;
      step;
      slp = 1'b0;
      @(negedge clk);
      chk({ch, ph, pi, po}, 8'h0e);
      step;
      wake = 1'b1;
      step;
      wake = 1'b0;
      wait_run(1'b1);
      if (i == 0) n0 = np;
      else chk(8'(np - n0), 8'(4 << sc[i]) - 8'h04);
      reg_op(1'b0, 16'hffc4, 8'h00);
      chk(rd, {1'b1, sc[i][2:0], 4'h8});
    end
    reg_op(1'b1, 16'hffc4, 8'h01);
    step;
    standby_pin_n_n = 1'b0;
    step;
    @(negedge clk);
    chk({ch, ph, pi, po}, 8'h0f);
    step;
    standby_pin_n_n = 1'b1;
    wait_run(1'b0);
    chk({np < 0, sm}, 8'h03);
    reg_op(1'b1, 16'hffc4, 8'h05);
    step;
    wdt = 1'b1;
    step;
    wdt = 1'b0;
    wait_run(1'b0);
    reg_op(1'b0, 16'hffc4, 8'h00);
    chk(rd, 8'h01);
    do_reset(1'b1, 1'b0);
    reg_op(1'b0, 16'hffc4, 8'h00);
    chk(rd, 8'h09);
    close_out;
  end
endmodule
